/* dv/mrdi_ram_model.sv */
module mrdi_ram_model (
  input wire logic clk_i,
  input wire logic [63:0] wdata_i,
  input wire logic [10:0] addr_i,
  input wire logic [17:0] sel_i,
  input wire logic we_i,
  input wire logic [3:0] fault_i,
  output logic [255:0] rdata_o = 256'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] mem [16];
  always @(posedge clk_i) begin
    if (sel_i != 18'h00000 && we_i) begin
      mem[addr_i[3:0]] <= wdata_i;
    end
    for (int c = 0; c < 4; c++) begin
      if (sel_i != 18'h00000 && !we_i) begin
        rdata_o[c*64 +: 64] <= mem[addr_i[3:0]] ^ {63'h0, fault_i[c]};
      end else begin
        // Idle lines toggle so stale data never looks valid
        rdata_o[c*64 +: 64] <= ~rdata_o[c*64 +: 64];
      end
    end
  end
endmodule

/* dv/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] q;
  logic ack;
  logic mux = 1'b0;
  logic strobe = 1'b0;
  logic sin = 1'b0;
  logic shift = 1'b0;
  logic run = 1'b0;
  logic [63:0] wd = 64'h0;
  logic [10:0] addr = 11'h000;
  logic [23:0] mask = 24'h000000;
  logic [17:0] asel = 18'h00000;
  logic [3:0] fault = 4'h0;
  logic [255:0] rd_o;
  logic [255:0] ram_rd;
  logic [63:0] r_wd;
  logic [10:0] r_adr;
  logic [23:0] r_mask;
  logic [17:0] r_sel;
  logic r_we;
  logic r_mux;
  logic sout;
  logic [55:0] ir;
  logic [6:0] csz_tab [4] = '{7'h10, 7'h10, 7'h20, 7'h40};
  int fail_count = 0;
  int cmp_count = 0;
  localparam logic [63:0] TDATA = 64'h0123_4567_89AB_CDEF;

  mrdi_dispatch #(.PARITY(1'b0)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ram_test_mux_select_i(mux), .test_write_data_i(wd), .test_address_i(addr),
    .test_write_mask_i(mask), .test_array_select_i(asel), .test_write_strobe_i(strobe),
    .instr_serial_in_i(sin), .instr_shift_enable_i(shift), .test_run_enable_i(run),
    .test_read_data_o(rd_o), .instr_serial_out_o(sout), .ram_test_mux_select_o(r_mux),
    .ram_write_data_o(r_wd), .ram_address_o(r_adr), .ram_write_mask_o(r_mask),
    .ram_array_select_o(r_sel), .ram_write_strobe_o(r_we), .ram_read_data_i(ram_rd)
  );

  mrdi_ram_model u_ram (
    .clk_i(clk_i), .wdata_i(r_wd), .addr_i(r_adr), .sel_i(r_sel), .we_i(r_we),
    .fault_i(fault), .rdata_o(ram_rd)
  );

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bus(input logic [255:0] got, input logic [255:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: bus got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      fail_count++;
      $display("Error at %0t: no acknowledge", $time);
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk_reg(q, exp);
  endtask

  task automatic load_ir(input logic [55:0] v);
    for (int i = 0; i < 56; i++) begin
      @(posedge clk_i);
      shift <= 1'b1;
      run <= 1'b0;
      sin <= v[i];
    end
    @(posedge clk_i);
    shift <= 1'b0;
    tick(4);
  endtask

  // Holds one access on the pins, then lets the pipeline settle
  task automatic set_pins(input logic m, input logic w, input logic [3:0] f);
    @(posedge clk_i);
    mux <= m;
    asel <= 18'h01000;
    strobe <= w;
    fault <= f;
    addr <= 11'h003;
    wd <= TDATA;
    mask <= 24'hFFFFFF;
    run <= 1'b1;
    tick(8);
  endtask

  task automatic chk_status(input logic [31:0] exp);
    wb(1'b0, mrdi_pkg::OFS_STATUS, 32'h0);
    chk_reg({25'h0, q[6:0]}, exp);
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    chk_bus({r_wd, r_adr, r_mask, r_sel, r_we, r_mux, sout, ack, rd_o[127:0]}, 256'h0);
    rst_i <= 1'b0;
    rd_chk(mrdi_pkg::OFS_CTRL, 32'h0);
    rd_chk(mrdi_pkg::OFS_STATUS, 32'h0);
    rd_chk(mrdi_pkg::OFS_IR_LO, 32'h0);
    rd_chk(mrdi_pkg::OFS_IR_HI, 32'h0);
    rd_chk(mrdi_pkg::OFS_DECODE, 32'h0000_1004);
    rd_chk(8'h20, 32'h0);
    for (int i = 0; i < 4; i++) begin
      ir = 56'h0;
      ir[55:50] = 6'h28 | 6'(i);
      ir[47:44] = 4'(3 * i);
      ir[43:41] = 3'(i + 1);
      ir[40:38] = 3'(7 - i);
      ir[25:22] = 4'(i + 9);
      ir[3:2] = 2'(i);
      ir[1:0] = 2'(i);
      load_ir(ir);
      rd_chk(mrdi_pkg::OFS_IR_LO, ir[31:0]);
      rd_chk(mrdi_pkg::OFS_IR_HI, {8'h00, ir[55:32]});
      rd_chk(mrdi_pkg::OFS_DECODE, {1'b0, ir[40:38], 1'b0, ir[43:41], ir[47:44], ir[25:22],
        1'b0, csz_tab[i], 2'b00, 6'h04 << i});
    end
    wb(1'b1, mrdi_pkg::OFS_CTRL, 32'h3);
    rd_chk(mrdi_pkg::OFS_CTRL, 32'h1);
    rd_chk(mrdi_pkg::OFS_DECODE, {1'b0, ir[40:38], 1'b0, ir[43:41], ir[47:44],
      mrdi_pkg::GO_NOGO_SEED, 1'b0, 7'h40, 2'b00, 6'h20});
    wb(1'b1, mrdi_pkg::OFS_CTRL, 32'h0);
    ir = 56'h0;
    ir[37:34] = 4'b0100;
    ir[33:26] = 8'hFF;
    ir[16] = 1'b1;
    load_ir(ir);
    set_pins(1'b1, 1'b1, 4'b0100);
    chk_bus({r_wd, r_adr, r_mask}, {TDATA, 11'h003, 24'hFFFFFF});
    chk_bus({r_sel, r_we, r_mux}, {18'h01000, 1'b1, 1'b1});
    wb(1'b1, mrdi_pkg::OFS_CTRL, 32'h2);
    tick(8);
    chk_status(32'h60);
    set_pins(1'b1, 1'b0, 4'b0010);
    chk_bus(rd_o, {TDATA, TDATA, TDATA ^ 64'h1, TDATA});
    chk_status(32'h20);
    set_pins(1'b1, 1'b0, 4'b0100);
    chk_bus(rd_o, {TDATA, TDATA ^ 64'h1, TDATA, TDATA});
    chk_status(32'h24);
    set_pins(1'b0, 1'b1, 4'b0000);
    chk_bus({r_sel, r_we, r_mux}, 256'h0);
    wb(1'b0, mrdi_pkg::OFS_STATUS, 32'h0);
    chk_reg({27'h0, q[5], q[3:0]}, 32'h04);
    print_verdict();
  end

  initial begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    $display("Error at %0t: timeout", $time);
    print_verdict();
  end
endmodule

/* rtl/mrdi_core_cmp.sv */
module mrdi_core_cmp #(
  parameter int unsigned DW = 64,
  parameter int unsigned MW = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [DW-1:0] rdata_i,
  input wire logic [DW-1:0] expect_i,
  input wire logic [MW-1:0] mask_i,
  input wire logic check_i,
  input wire logic clear_i,
  output logic fail_o
);
  logic [DW-1:0] bit_en;
  logic mismatch;
  logic fail_q;

  // Lines beyond the mask width are always compared
  always_comb begin
    for (int i = 0; i < DW; i++) begin
      bit_en[i] = (i < MW) ? mask_i[i] : 1'b1;
    end
  end

  assign mismatch = |((rdata_i ^ expect_i) & bit_en);

  // Sticky; a new failure beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fail_q <= 1'b0;
    end else if (check_i && mismatch) begin
      fail_q <= 1'b1;
    end else if (clear_i) begin
      fail_q <= 1'b0;
    end
  end

  assign fail_o = fail_q;
endmodule

/* rtl/mrdi_dispatch.sv */
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
module mrdi_dispatch #(
  parameter bit PARITY = 1'b0,
  parameter int unsigned DW = PARITY ? mrdi_pkg::DATA_W_PAR : mrdi_pkg::DATA_W_NOPAR,
  parameter int unsigned MW = PARITY ? mrdi_pkg::MASK_W_PAR : mrdi_pkg::MASK_W_NOPAR
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ram_test_mux_select_i,
  input wire logic [DW-1:0] test_write_data_i,
  input wire logic [mrdi_pkg::ADDR_W-1:0] test_address_i,
  input wire logic [MW-1:0] test_write_mask_i,
  input wire logic [mrdi_pkg::SEL_W-1:0] test_array_select_i,
  input wire logic test_write_strobe_i,
  input wire logic instr_serial_in_i,
  input wire logic instr_shift_enable_i,
  input wire logic test_run_enable_i,
  output logic [mrdi_pkg::NUM_CORES*DW-1:0] test_read_data_o,
  output logic instr_serial_out_o,
  output logic ram_test_mux_select_o,
  output logic [DW-1:0] ram_write_data_o,
  output logic [mrdi_pkg::ADDR_W-1:0] ram_address_o,
  output logic [MW-1:0] ram_write_mask_o,
  output logic [mrdi_pkg::SEL_W-1:0] ram_array_select_o,
  output logic ram_write_strobe_o,
  input wire logic [mrdi_pkg::NUM_CORES*DW-1:0] ram_read_data_i
);
  localparam int unsigned NC = mrdi_pkg::NUM_CORES;
  localparam int unsigned AW = mrdi_pkg::ADDR_W;
  localparam int unsigned SW = mrdi_pkg::SEL_W;
  localparam int unsigned PW = 1 + DW + AW + MW + SW + 1 + 3;

  // Two-flop synchroniser on every pin input
  logic [PW-1:0] pin_meta_q;
  logic [PW-1:0] pin_sync_q;
  logic mux_s;
  logic [DW-1:0] wdata_s;
  logic [AW-1:0] addr_s;
  logic [MW-1:0] mask_s;
  logic [SW-1:0] sel_s;
  logic we_s;
  logic serial_s;
  logic shift_s;
  logic run_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= {ram_test_mux_select_i, test_write_data_i, test_address_i,
                     test_write_mask_i, test_array_select_i, test_write_strobe_i,
                     instr_serial_in_i, instr_shift_enable_i, test_run_enable_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign {mux_s, wdata_s, addr_s, mask_s, sel_s, we_s, serial_s, shift_s, run_s} = pin_sync_q;

  // Instruction register
  logic [mrdi_pkg::IR_W-1:0] ir;

  mrdi_shift_ir u_ir (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .shift_i(shift_s),
    .run_i(run_s),
    .serial_i(serial_s),
    .ir_o(ir),
    .serial_o(instr_serial_out_o)
  );

  logic [NC-1:0] cpu_on;
  logic [3:0] max_x;
  logic [3:0] max_y;
  logic [3:0] seed_field;
  logic [SW-1:0] arr_en;
  logic [1:0] colw_code;
  logic [1:0] csz_code;
  logic [5:0] pattern;
  logic [5:0] flags;
  logic [2:0] wr_lat;
  logic [2:0] rd_lat;

  assign pattern = ir[mrdi_pkg::IR_PAT_HI:mrdi_pkg::IR_PAT_LO];
  assign flags = ir[mrdi_pkg::IR_FLG_HI:mrdi_pkg::IR_FLG_LO];
  assign wr_lat = ir[mrdi_pkg::IR_WLAT_HI:mrdi_pkg::IR_WLAT_LO];
  assign rd_lat = ir[mrdi_pkg::IR_RLAT_HI:mrdi_pkg::IR_RLAT_LO];
  assign cpu_on = ir[mrdi_pkg::IR_CPU_HI:mrdi_pkg::IR_CPU_LO];
  assign max_x = ir[mrdi_pkg::IR_MAXX_HI:mrdi_pkg::IR_MAXX_LO];
  assign max_y = ir[mrdi_pkg::IR_MAXY_HI:mrdi_pkg::IR_MAXY_LO];
  assign seed_field = ir[mrdi_pkg::IR_SEED_HI:mrdi_pkg::IR_SEED_LO];
  assign arr_en = ir[mrdi_pkg::IR_ARR_HI:mrdi_pkg::IR_ARR_LO];
  assign colw_code = ir[mrdi_pkg::IR_COLW_HI:mrdi_pkg::IR_COLW_LO];
  assign csz_code = ir[mrdi_pkg::IR_CSZ_HI:mrdi_pkg::IR_CSZ_LO];

  logic [5:0] col_width;
  logic [6:0] cache_kb;

  assign col_width = mrdi_pkg::COLW_BASE << colw_code;

  always_comb begin
    unique case (csz_code)
      2'b00: cache_kb = mrdi_pkg::CSZ_16KB;
      2'b01: cache_kb = mrdi_pkg::CSZ_16KB;
      2'b10: cache_kb = mrdi_pkg::CSZ_32KB;
      2'b11: cache_kb = mrdi_pkg::CSZ_64KB;
    endcase
  end

  // Control register and derived seed
  logic [31:0] ctrl_q;
  logic [3:0] seed;

  assign seed = ctrl_q[mrdi_pkg::CTRL_GONOGO] ? mrdi_pkg::GO_NOGO_SEED : seed_field;

  // Drive the arrays; array select and write strobe idle while the mux select is low, data, address and mask still follow the pins
  logic [SW-1:0] ram_sel_q;
  logic ram_we_q;
  logic [DW-1:0] ram_wdata_q;
  logic [AW-1:0] ram_addr_q;
  logic [MW-1:0] ram_mask_q;
  logic ram_mux_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ram_mux_q <= 1'b0;
      ram_sel_q <= '0;
      ram_we_q <= 1'b0;
    end else begin
      ram_mux_q <= mux_s;
      ram_sel_q <= mux_s ? sel_s : '0;
      ram_we_q <= mux_s & we_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ram_wdata_q <= '0;
      ram_addr_q <= '0;
      ram_mask_q <= '0;
    end else begin
      ram_wdata_q <= wdata_s;
      ram_addr_q <= addr_s;
      ram_mask_q <= mask_s;
    end
  end

  assign ram_test_mux_select_o = ram_mux_q;
  assign ram_array_select_o = ram_sel_q;
  assign ram_write_strobe_o = ram_we_q;
  assign ram_write_data_o = ram_wdata_q;
  assign ram_address_o = ram_addr_q;
  assign ram_write_mask_o = ram_mask_q;

  // Arrays answer one cycle after the access
  logic [NC*DW-1:0] rdata_q;
  logic check_q;
  logic [DW-1:0] expect_q;
  logic [MW-1:0] cmp_mask_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= '0;
      check_q <= 1'b0;
      expect_q <= '0;
      cmp_mask_q <= '0;
    end else begin
      rdata_q <= ram_read_data_i;
      check_q <= ram_mux_q && !ram_we_q && |(ram_sel_q & arr_en);
      expect_q <= ram_wdata_q;
      cmp_mask_q <= ram_mask_q;
    end
  end

  assign test_read_data_o = rdata_q;

  logic [NC-1:0] core_check;
  logic [NC-1:0] fail;
  logic clr_fail;

  assign core_check = {NC{check_q}} & cpu_on;

  for (genvar n = 0; n < NC; n++) begin : g_core
    mrdi_core_cmp #(
      .DW(DW),
      .MW(MW)
    ) u_cmp (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .rdata_i(ram_read_data_i[n*DW +: DW]),
      .expect_i(expect_q),
      .mask_i(cmp_mask_q),
      .check_i(core_check[n]),
      .clear_i(clr_fail),
      .fail_o(fail[n])
    );
  end

  // Sweep end reached at the column and row bounds
  logic addr_expired;

  assign addr_expired = ram_mux_q && (ram_addr_q[7:0] == {max_x, max_y});

  // Wishbone slave, answer one cycle after the request
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_mux;
  logic wr_hit;

  assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign clr_fail = wr_hit && (wb_adr_i == mrdi_pkg::OFS_CTRL) && wb_sel_i[0]
                    && wb_dat_i[mrdi_pkg::CTRL_CLRFAIL];

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      mrdi_pkg::OFS_CTRL: rd_mux = ctrl_q;
      mrdi_pkg::OFS_STATUS: rd_mux = {25'h0, we_s, ram_mux_q, addr_expired, fail};
      mrdi_pkg::OFS_IR_LO: rd_mux = ir[31:0];
      mrdi_pkg::OFS_IR_HI: rd_mux = {8'h00, ir[55:32]};
      mrdi_pkg::OFS_DECODE: rd_mux = {1'b0, rd_lat, 1'b0, wr_lat, flags[3:0], seed,
                                      1'b0, cache_kb, 2'h0, col_width};
      default: rd_mux = {26'h0, pattern};
    endcase
    if (!(wb_adr_i inside {mrdi_pkg::OFS_CTRL, mrdi_pkg::OFS_STATUS, mrdi_pkg::OFS_IR_LO,
                           mrdi_pkg::OFS_IR_HI, mrdi_pkg::OFS_DECODE})) begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      dat_q <= rd_mux;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= mrdi_pkg::CTRL_RESET;
    end else if (wr_hit && (wb_adr_i == mrdi_pkg::OFS_CTRL) && wb_sel_i[0]) begin
      ctrl_q[mrdi_pkg::CTRL_GONOGO] <= wb_dat_i[mrdi_pkg::CTRL_GONOGO];
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_STROBE_DELAY: assert property (
    !$past(rst_i, 4) |-> ram_write_strobe_o == ($past(test_write_strobe_i, 3)
                                               && $past(ram_test_mux_select_i, 3)))
    else $error("write strobe not a three-cycle copy of the pin");
  AST_SELECT_GATED: assert property (
    !ram_test_mux_select_o |-> ram_array_select_o == '0)
    else $error("array select active without test mux");
  AST_ADDR_PASS: assert property (
    !$past(rst_i, 4) |-> ram_address_o == $past(test_address_i, 3))
    else $error("address not passed to arrays");
  AST_NO_CMP_WRITE: assert property (
    ram_write_strobe_o |=> !check_q)
    else $error("compare during write");
  AST_CPU_GATE: assert property (
    ((fail & ~$past(fail)) & ~$past(cpu_on)) == '0)
    else $error("compare on disabled core");
  AST_RDATA_SLICE: assert property (
    !$past(rst_i) |-> test_read_data_o[DW-1:0] == $past(ram_read_data_i[DW-1:0]))
    else $error("core 0 read slice wrong");
  AST_IR_SHIFT: assert property (
    shift_s && !run_s |=> ir[mrdi_pkg::IR_W-1] == $past(serial_s) && ir[0] == $past(ir[1]))
    else $error("instruction register shift wrong");
  AST_IR_HOLD: assert property (
    run_s |=> $stable(ir))
    else $error("instruction register moved while running");
  AST_COLW: assert property (
    (colw_code == 2'b11) |-> col_width == 6'h20)
    else $error("column width decode wrong");
  AST_CACHE: assert property (
    (csz_code == 2'b01) |-> cache_kb == mrdi_pkg::CSZ_16KB)
    else $error("cache size decode wrong");
  AST_SEED: assert property (
    !ctrl_q[mrdi_pkg::CTRL_GONOGO] |-> seed == seed_field)
    else $error("seed overridden without go/nogo");
  AST_ACK: assert property (
    wb_cyc_i && wb_stb_i && !ack_q |=> ack_q ##1 !ack_q)
    else $error("bus ack timing wrong");
  AST_MUX_PASS: assert property (
    !$past(rst_i, 4) |-> ram_test_mux_select_o == $past(ram_test_mux_select_i, 3))
    else $error("test mux select not passed to arrays");
  AST_SEL_PASS: assert property (
    !$past(rst_i, 4) && ram_test_mux_select_o
      |-> ram_array_select_o == $past(test_array_select_i, 3))
    else $error("array select not passed to arrays");
  AST_WDATA_PASS: assert property (
    !$past(rst_i, 4) |-> ram_write_data_o == $past(test_write_data_i, 3))
    else $error("write data not passed to arrays");
  AST_FAIL_HOLD: assert property (
    !check_q && !clr_fail |=> $stable(fail))
    else $error("fail flags moved without compare or clear");
  AST_RDATA_TOP: assert property (
    !$past(rst_i) |-> test_read_data_o[NC*DW-1 -: DW]
                      == $past(ram_read_data_i[NC*DW-1 -: DW]))
    else $error("core 3 read slice wrong");

  COV_WRITE: cover property (ram_write_strobe_o && ram_array_select_o != '0);
  COV_CHECK: cover property (core_check != '0);
  COV_FAIL: cover property (fail != '0);
  COV_LOAD: cover property ((shift_s && !run_s) [*8]);
endmodule

/* rtl/mrdi_pkg.sv */
package mrdi_pkg;
  // Bus widths, without and with parity
  localparam int unsigned DATA_W_NOPAR = 64;
  localparam int unsigned DATA_W_PAR = 72;
  localparam int unsigned MASK_W_NOPAR = 24;
  localparam int unsigned MASK_W_PAR = 72;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned SEL_W = 18;
  localparam int unsigned NUM_CORES = 4;

  // Array-select bit positions
  localparam int unsigned SEL_CU_TAG_HI = 17;
  localparam int unsigned SEL_CU_TAG_LO = 16;
  localparam int unsigned SEL_DDATA_HI = 15;
  localparam int unsigned SEL_DDATA_LO = 12;
  localparam int unsigned SEL_DTAG_HI = 11;
  localparam int unsigned SEL_DTAG_LO = 10;
  localparam int unsigned SEL_DIRTY = 9;
  localparam int unsigned SEL_IDATA_HI = 8;
  localparam int unsigned SEL_IDATA_LO = 5;
  localparam int unsigned SEL_ITAG_HI = 4;
  localparam int unsigned SEL_ITAG_LO = 3;
  localparam int unsigned SEL_BTA = 2;
  localparam int unsigned SEL_TLB1 = 1;
  localparam int unsigned SEL_TLB0 = 0;

  // Instruction register layout
  localparam int unsigned IR_W = 56;
  localparam int unsigned IR_CTL_W = 18;
  localparam int unsigned IR_DSP_W = 38;
  localparam int unsigned IR_PAT_HI = 55;
  localparam int unsigned IR_PAT_LO = 50;
  localparam int unsigned IR_FLG_HI = 49;
  localparam int unsigned IR_FLG_LO = 44;
  localparam int unsigned IR_WLAT_HI = 43;
  localparam int unsigned IR_WLAT_LO = 41;
  localparam int unsigned IR_RLAT_HI = 40;
  localparam int unsigned IR_RLAT_LO = 38;
  localparam int unsigned IR_CPU_HI = 37;
  localparam int unsigned IR_CPU_LO = 34;
  localparam int unsigned IR_MAXX_HI = 33;
  localparam int unsigned IR_MAXX_LO = 30;
  localparam int unsigned IR_MAXY_HI = 29;
  localparam int unsigned IR_MAXY_LO = 26;
  localparam int unsigned IR_SEED_HI = 25;
  localparam int unsigned IR_SEED_LO = 22;
  localparam int unsigned IR_ARR_HI = 21;
  localparam int unsigned IR_ARR_LO = 4;
  localparam int unsigned IR_COLW_HI = 3;
  localparam int unsigned IR_COLW_LO = 2;
  localparam int unsigned IR_CSZ_HI = 1;
  localparam int unsigned IR_CSZ_LO = 0;
  localparam logic [IR_W-1:0] IR_RESET = 56'h00_0000_0000_0000;

  // Decoded field values
  localparam logic [5:0] COLW_BASE = 6'h04;
  localparam logic [6:0] CSZ_16KB = 7'h10;
  localparam logic [6:0] CSZ_32KB = 7'h20;
  localparam logic [6:0] CSZ_64KB = 7'h40;
  localparam logic [3:0] GO_NOGO_SEED = 4'h5;

  // Register map, byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IR_LO = 8'h08;
  localparam logic [7:0] OFS_IR_HI = 8'h0C;
  localparam logic [7:0] OFS_DECODE = 8'h10;
  localparam int unsigned CTRL_GONOGO = 0;
  localparam int unsigned CTRL_CLRFAIL = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
endpackage

/* rtl/mrdi_shift_ir.sv */
module mrdi_shift_ir (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic shift_i,
  input wire logic run_i,
  input wire logic serial_i,
  output logic [mrdi_pkg::IR_W-1:0] ir_o,
  output logic serial_o
);
  logic [mrdi_pkg::IR_W-1:0] ir_q;

  // Bit 0 enters first and ends up at the bottom after a full load
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ir_q <= mrdi_pkg::IR_RESET;
    end else if (shift_i && !run_i) begin
      ir_q <= {serial_i, ir_q[mrdi_pkg::IR_W-1:1]};
    end
  end

  assign ir_o = ir_q;
  assign serial_o = ir_q[0];
endmodule
